// *** logic/dscd_pkg.sv ***
// Constants shared by the serial command port of the octal converter.
// Assumes a 50 MHz system clock and a serial clock from an outside controller.
// Overview of operation
// - Chip select rising before the 24th falling edge discards the frame.
// - More than 24 falling edges: only the last 24 bits are decoded.
// - Frame is decoded and written out on the chip-select rising edge.
// - Input bits are captured on falling clock edges, most significant first.
// - With chip select high, clock and input are ignored, output floats.
// - Serial output drives only while the output-disable bit is 0, its reset value.
// - Sleep-select bit: 0 normal chaining, 1 bypass sleep chaining.
// - Normal chaining: overflow bits leave on output, change on rising edge.
// - Chip-select rise latches the frame and stops further shifting.
// - Sleep mode routes input to output directly and accepts no commands.
// - Wake pin low forces the sleep-select bit to 0.
// - With wake enable set, a frame of at most one edge ends sleep.
// - Frame: bit 23 read flag, 20..16 register select, 15..0 data.
// - Write frame stores its 16 data bits in the selected register.
// - Read frame: selected register is shifted out during the next frame.
// - Don't-care positions return 0 when read back.
// - Load strobe low updates all channel latches together.
`default_nettype none
package dscd_pkg;
  localparam int unsigned FRAME_BITS = 24;
  localparam int unsigned CNT_W      = 5;
  localparam logic [4:0]  FRAME_CNT  = 5'h18;
  localparam logic [4:0]  WAKE_MAX   = 5'h01;
  localparam int unsigned POS_RW     = 23;
  localparam int unsigned POS_SEL_HI = 20;
  localparam int unsigned POS_SEL_LO = 16;
  localparam int unsigned POS_DAT_HI = 15;
  localparam logic [4:0]  ADDR_CONFIG    = 5'h00;
  localparam logic [4:0]  ADDR_SPI_MODE  = 5'h06;
  localparam int unsigned POS_SLEEP      = 15;
  localparam int unsigned POS_SDO_DIS    = 6;
  localparam int unsigned POS_WAKE_EN    = 4;
  localparam logic        RST_SLEEP      = 1'h0;
  localparam logic        RST_SDO_DIS    = 1'h0;
  localparam logic        RST_WAKE_EN    = 1'h0;
  localparam logic [7:0]  READ_PAD       = 8'h00;
  localparam int unsigned SYNC_W         = 4;
  localparam logic [3:0]  SYNC_RST       = 4'he;
endpackage
`default_nettype wire

// *** logic/dscd_serial_port.sv ***
// Serial command port: shift register on the serial clock, decode on the system clock.
// Assumes the controller keeps the serial clock still while chip select is high,
// and that configuration bits change only between frames.
`timescale 1ns/1ps
`default_nettype none
module dscd_serial_port (
  input  wire logic        i_sys_clk,
  input  wire logic        i_rst,
  input  wire logic        i_spi_sclk,
  input  wire logic        i_cs_n,
  input  wire logic        i_sdi,
  input  wire logic        i_wake_pin_n,
  input  wire logic        i_channel_load_strobe_n,
  input  wire logic [15:0] i_rd_data,
  output logic             o_sdo,
  output logic             o_sdo_oe_n,
  output logic             o_wr_stb,
  output logic       [4:0] o_wr_addr,
  output logic      [15:0] o_wr_data,
  output logic       [4:0] o_rd_addr,
  output logic             o_load_all,
  output logic             o_sleep,
  output logic             o_serial_out_disable,
  output logic             o_cs_wake_enable
);
  typedef enum {IDLE, CAPTURE} dscd_state_type;

  typedef struct packed {
    logic [23:0] shift;
    logic [4:0]  count;
    logic        frame_tog;
  } dscd_link_type;

  typedef struct packed {
    dscd_state_type st;
    logic           cs_prev;
    logic           load_prev;
    logic           seen_tog;
    logic           sleep;
    logic           sdo_dis;
    logic           wake_en;
    logic           rd_pend;
    logic [4:0]     rd_addr;
    logic [15:0]    rd_word;
    logic           wr_stb;
    logic [4:0]     wr_addr;
    logic [15:0]    wr_data;
    logic           load_all;
  } dscd_sys_type;

  dscd_link_type link;
  dscd_link_type next_link;
  dscd_sys_type  sys;
  dscd_sys_type  next_sys;
  logic          fresh;
  logic          fresh_set;
  logic          sdo_q;
  logic [23:0]   src_word;
  logic [3:0]    sync_out;
  logic          cs_sync;
  logic          tog_sync;
  logic          wake_sync_n;
  logic          load_sync_n;
  logic          frame_end;
  logic [4:0]    edges;

  function automatic logic [4:0] sat_inc(input logic [4:0] c);
    sat_inc = (c >= dscd_pkg::FRAME_CNT) ? dscd_pkg::FRAME_CNT : c + 5'h01;
  endfunction

  // ---------------- Link side, serial clock ----------------

  // Outgoing word for this frame: pending read data or the old contents
  assign src_word = sys.rd_pend ? {dscd_pkg::READ_PAD, sys.rd_word} : link.shift;

  // First-edge marker, forced set while chip select is high
  assign fresh_set = i_cs_n | i_rst;

  always_ff @(negedge i_spi_sclk or posedge fresh_set) begin
    if (fresh_set) begin
      fresh <= 1'b1;
    end else begin
      fresh <= 1'b0;
    end
  end

  always_comb begin
    next_link = link;
    if (!i_cs_n) begin
      next_link.count = fresh ? 5'h01 : sat_inc(link.count);
      if (fresh) begin
        next_link.frame_tog = ~link.frame_tog;
      end
      if (!sys.sleep) begin
        if (fresh) begin
          next_link.shift = {src_word[22:0], i_sdi};
        end else begin
          next_link.shift = {link.shift[22:0], i_sdi};
        end
      end
    end
  end

  always_ff @(negedge i_spi_sclk or posedge i_rst) begin
    if (i_rst) begin
      link <= '0;
    end else begin
      link <= next_link;
    end
  end

  // Output bit moves on the rising edge, stable for the next falling edge
  always_ff @(posedge i_spi_sclk or posedge i_rst) begin
    if (i_rst) begin
      sdo_q <= 1'b0;
    end else if (!i_cs_n) begin
      sdo_q <= link.shift[23];
    end
  end

  // Sleep passes input straight through; otherwise the shift register tail
  assign o_sdo      = sys.sleep ? i_sdi : (fresh ? src_word[23] : sdo_q);
  assign o_sdo_oe_n = i_cs_n | sys.sdo_dis;

  // ---------------- Crossing into the system clock ----------------

  dscd_sync #(
    .W       (dscd_pkg::SYNC_W),
    .RST_VAL (dscd_pkg::SYNC_RST)
  ) u_sync (
    .i_clk   (i_sys_clk),
    .i_rst   (i_rst),
    .i_async ({i_channel_load_strobe_n, i_wake_pin_n, i_cs_n, link.frame_tog}),
    .o_sync  (sync_out)
  );

  assign tog_sync    = sync_out[0];
  assign cs_sync     = sync_out[1];
  assign wake_sync_n = sync_out[2];
  assign load_sync_n = sync_out[3];

  // Chip select has risen; link state is static until the next frame
  assign frame_end = cs_sync & ~sys.cs_prev;
  // No toggle since last frame means the frame saw no clock edge
  assign edges     = (tog_sync == sys.seen_tog) ? 5'h00 : link.count;

  // ---------------- System side ----------------

  always_comb begin
    next_sys           = sys;
    next_sys.cs_prev   = cs_sync;
    next_sys.load_prev = load_sync_n;
    next_sys.wr_stb    = 1'b0;
    next_sys.load_all  = sys.load_prev & ~load_sync_n;
    case (sys.st)
      IDLE: begin
        if (frame_end) begin
          next_sys.seen_tog = tog_sync;
          if (sys.sleep) begin
            if (sys.wake_en && edges <= dscd_pkg::WAKE_MAX) begin
              next_sys.sleep = 1'b0;
            end
          end else if (edges >= dscd_pkg::FRAME_CNT) begin
            next_sys.rd_pend = 1'b0;
            if (link.shift[dscd_pkg::POS_RW]) begin
              next_sys.rd_addr = link.shift[dscd_pkg::POS_SEL_HI:dscd_pkg::POS_SEL_LO];
              next_sys.st      = CAPTURE;
            end else begin
              next_sys.wr_stb  = 1'b1;
              next_sys.wr_addr = link.shift[dscd_pkg::POS_SEL_HI:dscd_pkg::POS_SEL_LO];
              next_sys.wr_data = link.shift[dscd_pkg::POS_DAT_HI:0];
              if (next_sys.wr_addr == dscd_pkg::ADDR_SPI_MODE) begin
                next_sys.sleep = link.shift[dscd_pkg::POS_SLEEP];
              end
              if (next_sys.wr_addr == dscd_pkg::ADDR_CONFIG) begin
                next_sys.sdo_dis = link.shift[dscd_pkg::POS_SDO_DIS];
                next_sys.wake_en = link.shift[dscd_pkg::POS_WAKE_EN];
              end
            end
          end
        end
      end
      CAPTURE: begin
        next_sys.rd_word = i_rd_data;
        next_sys.rd_pend = 1'b1;
        next_sys.st      = IDLE;
      end
      default: begin
        next_sys.st = IDLE;
      end
    endcase
    if (!wake_sync_n) begin
      next_sys.sleep = 1'b0;
    end
  end

  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      sys.st        <= IDLE;
      sys.cs_prev   <= 1'b1;
      sys.load_prev <= 1'b1;
      sys.seen_tog  <= 1'b0;
      sys.sleep     <= dscd_pkg::RST_SLEEP;
      sys.sdo_dis   <= dscd_pkg::RST_SDO_DIS;
      sys.wake_en   <= dscd_pkg::RST_WAKE_EN;
      sys.rd_pend   <= 1'b0;
      sys.rd_addr   <= 5'h00;
      sys.rd_word   <= 16'h0000;
      sys.wr_stb    <= 1'b0;
      sys.wr_addr   <= 5'h00;
      sys.wr_data   <= 16'h0000;
      sys.load_all  <= 1'b0;
    end else begin
      sys <= next_sys;
    end
  end

  assign o_wr_stb             = sys.wr_stb;
  assign o_wr_addr            = sys.wr_addr;
  assign o_wr_data            = sys.wr_data;
  assign o_rd_addr            = sys.rd_addr;
  assign o_load_all           = sys.load_all;
  assign o_sleep              = sys.sleep;
  assign o_serial_out_disable = sys.sdo_dis;
  assign o_cs_wake_enable     = sys.wake_en;

  // ---------------- Checks ----------------

  a_short_frame_drop: assert property (
    @(posedge i_sys_clk) disable iff (i_rst)
    (sys.st == IDLE && frame_end && edges < dscd_pkg::FRAME_CNT) |=> !o_wr_stb)
    else $error("short frame produced a write");

  a_write_decode: assert property (
    @(posedge i_sys_clk) disable iff (i_rst)
    (sys.st == IDLE && frame_end && !sys.sleep && edges >= dscd_pkg::FRAME_CNT
     && !link.shift[23])
    |=> o_wr_stb && o_wr_addr == $past(link.shift[20:16]) && o_wr_data == $past(link.shift[15:0]))
    else $error("write frame not decoded correctly");

  a_sleep_no_cmd: assert property (
    @(posedge i_sys_clk) disable iff (i_rst)
    (frame_end && sys.sleep) |=> !o_wr_stb ##1 !o_wr_stb)
    else $error("command accepted while asleep");

  a_wake_pin_clear: assert property (
    @(posedge i_sys_clk) disable iff (i_rst)
    !wake_sync_n |=> !o_sleep)
    else $error("wake pin did not clear sleep");

  a_cs_wake_exit: assert property (
    @(posedge i_sys_clk) disable iff (i_rst)
    (sys.st == IDLE && frame_end && sys.sleep && sys.wake_en && edges <= 5'h01)
    |=> !o_sleep)
    else $error("short frame did not wake the port");

  a_read_capture: assert property (
    @(posedge i_sys_clk) disable iff (i_rst)
    (sys.st == IDLE && frame_end && !sys.sleep && edges >= dscd_pkg::FRAME_CNT
     && link.shift[23])
    |=> o_rd_addr == $past(link.shift[20:16]) ##1 sys.rd_pend && !o_wr_stb)
    else $error("read frame not captured");

  a_reset_awake: assert property (
    @(posedge i_sys_clk) $past(i_rst) |-> !o_sleep)
    else $error("sleep set after reset");

  a_sdo_float: assert property (
    @(posedge i_sys_clk) disable iff (i_rst)
    (o_serial_out_disable || i_cs_n) |-> o_sdo_oe_n)
    else $error("serial output driven while disabled");

  a_load_pulse: assert property (
    @(posedge i_sys_clk) disable iff (i_rst)
    $fell(load_sync_n) |=> o_load_all ##1 !o_load_all)
    else $error("load strobe not passed on");

  a_shift_capture: assert property (
    @(negedge i_spi_sclk) disable iff (i_rst)
    (!i_cs_n && !sys.sleep) |=> link.shift[0] == $past(i_sdi))
    else $error("input bit not captured");

  a_bypass_path: assert property (
    @(negedge i_spi_sclk) disable iff (i_rst)
    sys.sleep |-> o_sdo == i_sdi)
    else $error("sleep bypass broken");

  a_strobe_single: assert property (
    @(posedge i_sys_clk) disable iff (i_rst)
    o_wr_stb |=> !o_wr_stb)
    else $error("write strobe longer than one cycle");

  a_write_after_frame: assert property (
    @(posedge i_sys_clk) disable iff (i_rst)
    o_wr_stb |-> $past(frame_end))
    else $error("write without a chip-select rise");

  a_config_snoop: assert property (
    @(posedge i_sys_clk) disable iff (i_rst)
    (o_wr_stb && o_wr_addr == dscd_pkg::ADDR_CONFIG)
    |-> (o_serial_out_disable == o_wr_data[dscd_pkg::POS_SDO_DIS]
         && o_cs_wake_enable == o_wr_data[dscd_pkg::POS_WAKE_EN]))
    else $error("configuration bits not taken from the write");

  a_mode_snoop: assert property (
    @(posedge i_sys_clk) disable iff (i_rst)
    (o_wr_stb && o_wr_addr == dscd_pkg::ADDR_SPI_MODE && $past(wake_sync_n))
    |-> o_sleep == o_wr_data[dscd_pkg::POS_SLEEP])
    else $error("sleep bit not taken from the write");

  a_sleep_source: assert property (
    @(posedge i_sys_clk) disable iff (i_rst)
    $rose(o_sleep) |-> $past(frame_end))
    else $error("sleep set without a frame");

  a_asleep_frozen: assert property (
    @(negedge i_spi_sclk) disable iff (i_rst)
    sys.sleep |=> $stable(link.shift))
    else $error("shift register moved while asleep");
endmodule // dscd_serial_port
`default_nettype wire

// *** logic/dscd_sync.sv ***
// Two-flop synchroniser for a group of independent levels.
// Assumes each bit changes slowly against the destination clock.
`timescale 1ns/1ps
`default_nettype none
module dscd_sync #(
  parameter int unsigned W         = 1,
  parameter logic [W-1:0] RST_VAL  = '0
) (
  input  wire logic         i_clk,
  input  wire logic         i_rst,
  input  wire logic [W-1:0] i_async,
  output logic      [W-1:0] o_sync
);
  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] stable;
  } dscd_sync_type;

  dscd_sync_type state;
  dscd_sync_type next_state;

  always_comb begin
    next_state.meta   = i_async;
    next_state.stable = state.meta;
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      state <= {RST_VAL, RST_VAL};
    end else begin
      state <= next_state;
    end
  end

  assign o_sync = state.stable;
endmodule // dscd_sync
`default_nettype wire

// *** test/dac_serial_port_daisy_chain_bench.sv ***
// Self-checking bench for the serial command port of the octal converter.
// Assumes the controller model drives the link; the port's assertions stand inside it.
`timescale 1ns/1ps
`default_nettype none
module dac_serial_port_daisy_chain_bench;
  logic        i_sys_clk = 1'b0;
  logic        i_rst;
  logic        wake_n    = 1'b1;
  logic        load_n    = 1'b1;
  wire  logic [15:0] rd_data;
  logic        sclk, cs_n, sdi, sdo, sdo_oe_n, wr_stb, load_all, sleep, dis_o, wen_o;
  logic [4:0]  wr_addr, rd_addr;
  logic [15:0] wr_data;
  int          n_fail = 0;
  int          comparisons = 0;
  int          stb_cnt = 0;
  int          ld_cnt = 0;
  logic [23:0] prev = '0;
  logic        slp = 1'b0;
  logic        dis = 1'b0;
  logic        wen = 1'b0;
  logic        rdp = 1'b0;

  always #10 i_sys_clk = ~i_sys_clk;

  dscd_ctl_model ctl (.o_sclk(sclk), .o_cs_n(cs_n), .o_sdi(sdi), .i_sdo(sdo),
                      .i_sdo_oe_n(sdo_oe_n));
  dscd_serial_port DUT (.i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_spi_sclk(sclk),
    .i_cs_n(cs_n), .i_sdi(sdi), .i_wake_pin_n(wake_n), .i_channel_load_strobe_n(load_n),
    .i_rd_data(rd_data), .o_sdo(sdo), .o_sdo_oe_n(sdo_oe_n), .o_wr_stb(wr_stb),
    .o_wr_addr(wr_addr), .o_wr_data(wr_data), .o_rd_addr(rd_addr), .o_load_all(load_all),
    .o_sleep(sleep), .o_serial_out_disable(dis_o), .o_cs_wake_enable(wen_o));

  // Register file stand-in: contents follow the address pattern
  function automatic logic [15:0] rd_val(input logic [4:0] a);
    return {a, 3'h5, a, 3'h2};
  endfunction
  function automatic logic [63:0] rnd_word(input logic rw);
    logic [31:0] r;
    r = $urandom;
    return {40'h0, rw, r[22:21], 2'b01, r[18:0]};
  endfunction

  // Register file read port answers within the cycle of the address
  assign rd_data = rd_val(rd_addr);

  always @(posedge i_sys_clk) begin
    if (wr_stb === 1'b1) stb_cnt <= stb_cnt + 1;
    if (load_all === 1'b1) ld_cnt <= ld_cnt + 1;
  end

  task automatic chk(input logic [63:0] got, input logic [63:0] exp, input string what);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  task automatic done(input string name);
    $display("test %s finished", name);
  endtask
  task automatic close_out;
    $display("comparisons %0d mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  // One frame of n edges, with every expectation worked out from the bench state
  task automatic frame(input logic [63:0] w, input int n);
    logic [63:0] got;
    int          drv;
    int          s0;
    logic        acc;
    s0 = stb_cnt;
    acc = !slp && n >= 24;
    ctl.xfer(w, n, got, drv);
    repeat (12) @(posedge i_sys_clk);
    chk(sdo_oe_n, 1'b1, "float");
    chk(drv, dis ? 0 : n, "drive");
    if (slp) chk(got, w, "bypass");
    else if (!dis && n >= 24) chk(got >> (n - 24), prev, "chain");
    chk(stb_cnt - s0, acc && !w[23], "strobe");
    if (acc && !w[23]) begin
      chk(wr_addr, w[20:16], "addr");
      chk(wr_data, w[15:0], "data");
      if (w[20:16] == 5'h06) slp = w[15];
      if (w[20:16] == 5'h00) begin
        dis = w[6];
        wen = w[4];
      end
    end
    if (acc && w[23]) chk(rd_addr, w[20:16], "read addr");
    if (acc) prev = w[23] ? {8'h00, rd_val(w[20:16])} : w[23:0];
    else if (!slp && !rdp) prev = 24'(({40'h0, prev} << n) | (w & ((64'h1 << n) - 64'h1)));
    else if (slp && wen && n <= 1) slp = 1'b0;
    if (acc) rdp = w[23];
    chk(sleep, slp, "sleep");
    chk(dis_o, dis, "disable");
    chk(wen_o, wen, "wake enable");
  endtask

  initial begin
    #1000us;
    n_fail++;
    $display("wrong value at %0t: run did not finish", $time);
    close_out();
  end

  initial begin
    i_rst <= 1'b1;
    void'($urandom(70412));
    repeat (8) @(posedge i_sys_clk);
    i_rst <= 1'b0;
    repeat (4) @(posedge i_sys_clk);
    chk(sleep, 1'b0, "reset sleep");
    chk(dis_o, 1'b0, "reset disable");
    done("reset");
    repeat (6) frame(rnd_word(1'b0), 24);
    done("writes");
    frame(rnd_word(1'b0), 23);
    frame(rnd_word(1'b0), 1);
    frame((64'h15 << 24) | rnd_word(1'b0), 30);
    done("frame length");
    repeat (3) frame(rnd_word(1'b1), 24);
    frame(rnd_word(1'b0), 24);
    done("read back");
    frame(64'h000040, 24);
    frame(rnd_word(1'b0), 24);
    frame(64'h000000, 24);
    done("output disable");
    frame(64'h068000, 24);
    frame(rnd_word(1'b0), 24);
    frame(64'h1, 1);
    @(posedge i_sys_clk) wake_n <= 1'b0;
    repeat (5) @(posedge i_sys_clk);
    wake_n <= 1'b1;
    repeat (3) @(posedge i_sys_clk);
    slp = 1'b0;
    chk(sleep, 1'b0, "wake pin");
    frame(64'h000010, 24);
    frame(64'h068000, 24);
    frame(64'h2, 2);
    frame(64'h1, 1);
    frame(rnd_word(1'b0), 24);
    done("sleep");
    ld_cnt = 0;
    @(posedge i_sys_clk) load_n <= 1'b0;
    repeat (8) @(posedge i_sys_clk);
    load_n <= 1'b1;
    repeat (8) @(posedge i_sys_clk);
    chk(ld_cnt, 1, "load pulses");
    done("load");
    close_out();
  end
endmodule // dac_serial_port_daisy_chain_bench
`default_nettype wire

// *** test/dscd_ctl_model.sv ***
// Controller model that frames words onto the serial command port.
// Assumes the port captures on falling clock edges and shifts out on rising ones.
`timescale 1ns/1ps
`default_nettype none
module dscd_ctl_model (
  output logic      o_sclk,
  output logic      o_cs_n,
  output logic      o_sdi,
  input  wire logic i_sdo,
  input  wire logic i_sdo_oe_n
);
  initial begin
    o_sclk = 1'b0;
    o_cs_n = 1'b1;
    o_sdi  = 1'b0;
  end
  // Sends the low n bits of w, most significant first, and samples the output
  task automatic xfer(input logic [63:0] w, input int n,
                      output logic [63:0] got, output int drv);
    got = '0;
    drv = 0;
    // Start the frame off the system clock edge
    #7;
    o_cs_n = 1'b0;
    #40;
    for (int i = n - 1; i >= 0; i--) begin
      o_sclk = 1'b1;
      o_sdi  = w[i];
      #80;
      got = {got[62:0], i_sdo};
      if (i_sdo_oe_n === 1'b0) drv++;
      o_sclk = 1'b0;
      #80;
    end
    o_cs_n = 1'b1;
    // Released line no longer shows the last bit
    o_sdi  = ~o_sdi;
  endtask
endmodule // dscd_ctl_model
`default_nettype wire
